// ### shared/lapb_pkg.sv
// Constants and types shared by the LED and audio power-budget manager
package lapb_pkg;

    // Configuration register location, reset value and writable bits
    localparam logic [7:0] BUDGET_ADDR = 8'h0D;
    localparam logic [7:0] BUDGET_RESET = 8'h02;
    localparam logic [7:0] BUDGET_WMASK = 8'h1B;
    localparam int LED_POL_BIT = 4;
    localparam int AUD_POL_BIT = 3;
    localparam int BOOST_POL_LSB = 0;
    localparam int BOOST_POL_MSB = 1;

    // Boost-voltage policy field encodings
    typedef enum logic [1:0] {
        BOOST_MAX_DEMAND = 2'b00,
        BOOST_LED_ONLY = 2'b01,
        BOOST_BYPASS = 2'b10,
        BOOST_FIXED_5V = 2'b11
    } lapb_boost_t;

    // Budget manager states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_LED_CUT = 2'b10
    } lapb_state_t;

    // Speaker gain codes: 000 mute, 001 lowest audible, 100 highest valid
    localparam int GAIN_W = 3;
    localparam logic [2:0] GAIN_FLOOR = 3'h1;
    localparam logic [2:0] GAIN_MAX_VALID = 3'h4;
    localparam logic [2:0] GAIN_STEP = 3'h1;

    // Timing: settle after the audio cut, spacing of LED current steps
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_NS = 10000;
    localparam int LED_STEP_TIME_NS = 20000;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_STEP_CYCLES =
        (LED_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

endpackage : lapb_pkg

// ### verilog/lapb_step_down.sv
// Saturating step-down of a code, never going below a floor
`timescale 1ns/1ps
module lapb_step_down #(
    parameter int W = 3
) (
    // Operands
    input wire logic [W-1:0] value_in,
    input wire logic [W-1:0] steps_in,
    input wire logic [W-1:0] floor_in,
    // Result
    output logic [W-1:0] value_out
);

    // Codes at or below the floor pass unchanged
    always_comb begin
        if (value_in <= floor_in) begin
            value_out = value_in;
        end else if ((value_in - floor_in) < steps_in) begin
            value_out = floor_in;
        end else begin
            value_out = value_in - steps_in;
        end
    end

endmodule : lapb_step_down

// ### verilog/lapb_power_budget_mgr.sv
// LED and audio power-budget manager with its configuration register
//
// Summary of operation
// RL1 - LED policy clear: step LED current down under overload, held until LED event ends.
// RL2 - LED policy set: LED current passes exactly as software programmed.
// RL3 - Audio policy clear, LEDs active, overload, gain code 2 to 4: cut speaker gain once.
// RL4 - Overload persisting after the audio cut hands over to LED policy.
// RL5 - End of LED event restores original speaker gain automatically.
// RL6 - Audio policy set: no automatic gain cut during LED activity.
// RL7 - Boost field 00: target is larger of Class G and LED demand.
// RL8 - Boost field 01: LED demand while LEDs on, bypass while off.
// RL9 - Boost field 10, reset value: boost held in bypass.
// RL10 - Boost field 11: boost regulated to fixed 5 V code.
// RL11 - One audio cut lowers the programmed gain code by one step.
// RL12 - Reserved bits 7:5 and 2 read zero, writes ignored.
// RL13 - LED activity from LED drivers, overload from thermal and limit.
`timescale 1ns/1ps
module lapb_power_budget_mgr #(
    parameter int LED_W = 4,
    parameter int DEM_W = 8,
    parameter logic [7:0] FIXED_5V_CODE = 8'h50,
    parameter int SETTLE_CYCLES = lapb_pkg::SETTLE_CYCLES,
    parameter int LED_STEP_CYCLES = lapb_pkg::LED_STEP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Activity and overload indications
    input wire logic led_active_in,
    input wire logic thermal_near_in,
    input wire logic current_limit_in,
    // Programmed settings and voltage demands
    input wire logic [2:0] speaker_gain_field_in,
    input wire logic [LED_W-1:0] led_current_in,
    input wire logic [DEM_W-1:0] classg_demand_in,
    input wire logic [DEM_W-1:0] led_demand_in,
    // Applied settings and status
    output logic [2:0] speaker_gain_out,
    output logic [LED_W-1:0] led_current_out,
    output logic [DEM_W-1:0] boost_target_out,
    output logic boost_bypass_out,
    output logic audio_cut_out,
    output logic led_cut_out
);

    localparam int TW = lapb_pkg::TIMER_W;
    localparam logic [TW-1:0] SETTLE_LOAD = TW'(SETTLE_CYCLES - 1);
    localparam logic [TW-1:0] STEP_LOAD = TW'(LED_STEP_CYCLES - 1);
    localparam logic [LED_W-1:0] LED_CUT_MAX = {LED_W{1'b1}};
    localparam logic [LED_W-1:0] LED_ONE = LED_W'(1);

    // Configuration register
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic led_pol;
    logic aud_pol;
    lapb_pkg::lapb_boost_t boost_pol;

    // Write and read decode; reserved bits are never stored
    always_comb begin
        cfg_next = cfg_reg;
        rdata_next = 8'h00;
        if (reg_wr_in && reg_addr_in == lapb_pkg::BUDGET_ADDR) begin
            cfg_next = reg_wdata_in & lapb_pkg::BUDGET_WMASK; // RL12
        end
        if (reg_rd_in && reg_addr_in == lapb_pkg::BUDGET_ADDR) begin
            rdata_next = cfg_reg; // RL12
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_reg <= lapb_pkg::BUDGET_RESET; // RL9
            rdata_reg <= 8'h00;
        end else begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign led_pol = cfg_reg[lapb_pkg::LED_POL_BIT];
    assign aud_pol = cfg_reg[lapb_pkg::AUD_POL_BIT];
    assign boost_pol = lapb_pkg::lapb_boost_t'(
        cfg_reg[lapb_pkg::BOOST_POL_MSB:lapb_pkg::BOOST_POL_LSB]);

    // Overload pins come from analog monitors, so two flops each
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic overload;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= {current_limit_in, thermal_near_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign overload = |sync2_reg; // RL13

    // Budget sequencer state
    lapb_pkg::lapb_state_t state_reg;
    lapb_pkg::lapb_state_t state_next;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] timer_next;
    logic audio_cut_reg;
    logic audio_cut_next;
    logic [LED_W-1:0] led_cut_reg;
    logic [LED_W-1:0] led_cut_next;
    logic gain_valid;
    logic gain_cuttable;

    // Mute and reserved gain codes are never stepped
    assign gain_valid = speaker_gain_field_in <= lapb_pkg::GAIN_MAX_VALID;
    assign gain_cuttable = gain_valid &&
        speaker_gain_field_in > lapb_pkg::GAIN_FLOOR;

    // The audio cut is taken once per LED event, then LED policy rules
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        audio_cut_next = audio_cut_reg;
        led_cut_next = led_cut_reg;
        if (!led_active_in) begin
            state_next = lapb_pkg::ST_IDLE; // RL5
            timer_next = '0;
            audio_cut_next = 1'b0; // RL5
            led_cut_next = '0;
        end else begin
            unique case (state_reg)
                lapb_pkg::ST_IDLE: begin
                    if (overload && !aud_pol && gain_cuttable) begin
                        audio_cut_next = 1'b1; // RL3
                        state_next = lapb_pkg::ST_SETTLE;
                        timer_next = SETTLE_LOAD;
                    end else if (overload) begin
                        state_next = lapb_pkg::ST_LED_CUT; // RL6
                        timer_next = '0;
                    end
                end
                lapb_pkg::ST_SETTLE: begin
                    // Let the amplifier settle before judging the cut
                    if (timer_reg != '0) begin
                        timer_next = timer_reg - 1'b1;
                    end else if (overload) begin
                        state_next = lapb_pkg::ST_LED_CUT; // RL4
                    end
                end
                lapb_pkg::ST_LED_CUT: begin
                    if (timer_reg != '0) begin
                        timer_next = timer_reg - 1'b1;
                    end else if (overload && !led_pol &&
                                 led_cut_reg != LED_CUT_MAX) begin
                        led_cut_next = led_cut_reg + LED_ONE; // RL1
                        timer_next = STEP_LOAD;
                    end
                end
                default: begin
                    state_next = lapb_pkg::ST_IDLE;
                end
            endcase
            if (led_pol) begin
                led_cut_next = '0; // RL2
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= lapb_pkg::ST_IDLE;
            timer_reg <= '0;
            audio_cut_reg <= 1'b0;
            led_cut_reg <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            audio_cut_reg <= audio_cut_next;
            led_cut_reg <= led_cut_next;
        end
    end

    // Applied settings, derived from the programmed ones
    logic [2:0] gain_steps;
    logic [2:0] gain_applied;
    logic [LED_W-1:0] led_steps;
    logic [LED_W-1:0] led_applied;

    // Policy bits gate the cuts directly so a change takes effect at once
    assign gain_steps = (audio_cut_reg && !aud_pol && gain_valid) ?
        lapb_pkg::GAIN_STEP : 3'h0; // RL11
    assign led_steps = led_pol ? '0 : led_cut_reg; // RL2

    lapb_step_down #(
        .W(lapb_pkg::GAIN_W)
    ) u_gain_step (
        .value_in(speaker_gain_field_in),
        .steps_in(gain_steps),
        .floor_in(lapb_pkg::GAIN_FLOOR),
        .value_out(gain_applied)
    );

    lapb_step_down #(
        .W(LED_W)
    ) u_led_step (
        .value_in(led_current_in),
        .steps_in(led_steps),
        .floor_in('0),
        .value_out(led_applied)
    );

    // Boost target selection
    logic [DEM_W-1:0] target_next;
    logic bypass_next;

    always_comb begin
        target_next = '0;
        bypass_next = 1'b1;
        unique case (boost_pol)
            lapb_pkg::BOOST_MAX_DEMAND: begin
                bypass_next = 1'b0;
                target_next = (classg_demand_in > led_demand_in) ?
                    classg_demand_in : led_demand_in; // RL7
            end
            lapb_pkg::BOOST_LED_ONLY: begin
                bypass_next = !led_active_in; // RL8
                target_next = led_active_in ? led_demand_in : '0; // RL8
            end
            lapb_pkg::BOOST_BYPASS: begin
                bypass_next = 1'b1; // RL9
            end
            lapb_pkg::BOOST_FIXED_5V: begin
                bypass_next = 1'b0;
                target_next = DEM_W'(FIXED_5V_CODE); // RL10
            end
        endcase
    end

    // Output flops; one cycle behind the settings they follow
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speaker_gain_out <= 3'h0;
            led_current_out <= '0;
            boost_target_out <= '0;
            boost_bypass_out <= 1'b1;
            audio_cut_out <= 1'b0;
            led_cut_out <= 1'b0;
        end else begin
            speaker_gain_out <= gain_applied;
            led_current_out <= led_applied;
            boost_target_out <= target_next;
            boost_bypass_out <= bypass_next;
            audio_cut_out <= gain_steps != 3'h0;
            led_cut_out <= led_steps != '0;
        end
    end

    assign reg_rdata_out = rdata_reg;

endmodule : lapb_power_budget_mgr

// ### test/lapb_mgr_monitor.sv
// Port-level checker for the LED and audio power-budget manager
`timescale 1ns/1ps
module lapb_mgr_monitor #(
    parameter int LED_W = 4,
    parameter int DEM_W = 8,
    parameter logic [7:0] FIXED_5V_CODE = 8'h50
) (
    // Clock, reset and register port
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Indications and programmed values
    input wire logic led_active_in,
    input wire logic thermal_near_in,
    input wire logic current_limit_in,
    input wire logic [2:0] speaker_gain_field_in,
    input wire logic [LED_W-1:0] led_current_in,
    input wire logic [DEM_W-1:0] classg_demand_in,
    input wire logic [DEM_W-1:0] led_demand_in,
    // Applied values
    input wire logic [2:0] speaker_gain_out,
    input wire logic [LED_W-1:0] led_current_out,
    input wire logic [DEM_W-1:0] boost_target_out,
    input wire logic boost_bypass_out,
    input wire logic audio_cut_out,
    input wire logic led_cut_out
);
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [DEM_W-1:0] max_dem;
    // Shadow of the policy register, since the ports do not show it
    always_comb begin
        cfg_next = cfg_reg;
        if (reg_wr_in && reg_addr_in == lapb_pkg::BUDGET_ADDR) begin
            cfg_next = reg_wdata_in & lapb_pkg::BUDGET_WMASK;
        end
        max_dem = (classg_demand_in > led_demand_in) ? classg_demand_in
            : led_demand_in;
    end
    // Shadow register update
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) cfg_reg <= lapb_pkg::BUDGET_RESET;
        else cfg_reg <= cfg_next;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Overload held through the synchroniser delay during an LED event
    sequence s_overload;
        (led_active_in && (thermal_near_in || current_limit_in)
            && !cfg_reg[3] && speaker_gain_field_in == 3'h3) [*4];
    endsequence
    sequence s_gain_cut;
        ##[0:2] audio_cut_out;
    endsequence
    property p_audio_cut;
        s_overload |-> s_gain_cut;
    endproperty
    property p_gain_step;
        audio_cut_out |-> speaker_gain_out == $past(speaker_gain_field_in)
            - 3'h1;
    endproperty
    property p_rd_data;
        reg_rd_in && reg_addr_in == lapb_pkg::BUDGET_ADDR
            |=> reg_rdata_out == $past(cfg_reg);
    endproperty
    property p_boost_max;
        cfg_reg[1:0] == 2'b00 |=> !boost_bypass_out
            && boost_target_out == $past(max_dem);
    endproperty
    property p_boost_led;
        cfg_reg[1:0] == 2'b01 |=> ($past(led_active_in) ? (!boost_bypass_out
            && boost_target_out == $past(led_demand_in))
            : (boost_bypass_out && boost_target_out == '0));
    endproperty
    property p_boost_byp;
        cfg_reg[1:0] == 2'b10 |=> boost_bypass_out && boost_target_out == '0;
    endproperty
    property p_boost_5v;
        cfg_reg[1:0] == 2'b11 |=> !boost_bypass_out
            && boost_target_out == FIXED_5V_CODE;
    endproperty
    property p_led_pol;
        cfg_reg[4] ##1 cfg_reg[4] |=> !led_cut_out
            && led_current_out == $past(led_current_in);
    endproperty
    property p_aud_pol;
        cfg_reg[3] ##1 cfg_reg[3] |=> !audio_cut_out
            && speaker_gain_out == $past(speaker_gain_field_in);
    endproperty
    property p_restore;
        $fell(led_active_in) |-> ##[1:3] (!audio_cut_out && !led_cut_out);
    endproperty
    a_audio_cut: assert property (p_audio_cut) else $error("no gain cut");
    a_gain_step: assert property (p_gain_step) else $error("bad step");
    a_rd_data: assert property (p_rd_data) else $error("bad rdata");
    a_boost_max: assert property (p_boost_max) else $error("mode 00");
    a_boost_led: assert property (p_boost_led) else $error("mode 01");
    a_boost_byp: assert property (p_boost_byp) else $error("mode 10");
    a_boost_5v: assert property (p_boost_5v) else $error("mode 11");
    a_led_pol: assert property (p_led_pol) else $error("led changed");
    a_aud_pol: assert property (p_aud_pol) else $error("gain changed");
    a_restore: assert property (p_restore) else $error("no restore");
endmodule : lapb_mgr_monitor
bind lapb_power_budget_mgr lapb_mgr_monitor #(.LED_W(LED_W), .DEM_W(DEM_W),
    .FIXED_5V_CODE(FIXED_5V_CODE)) u_lapb_mgr_monitor (.sys_clk_in,
    .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .led_active_in, .thermal_near_in, .current_limit_in,
    .speaker_gain_field_in, .led_current_in, .classg_demand_in,
    .led_demand_in, .speaker_gain_out, .led_current_out, .boost_target_out,
    .boost_bypass_out, .audio_cut_out, .led_cut_out);

// ### test/tb_lapb_power_budget_mgr.sv
// Self-checking testbench for the power-budget manager
`timescale 1ns/1ps
module tb_lapb_power_budget_mgr;
    logic sys_clk_in = 1'b0, nrst_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, led_active_in = 1'b0;
    logic thermal_near_in = 1'b0, current_limit_in = 1'b0;
    logic [2:0] speaker_gain_field_in = 3'h3, speaker_gain_out;
    logic [3:0] led_current_in = 4'h9, led_current_out;
    logic [7:0] classg_demand_in = 8'h62, led_demand_in = 8'h41;
    logic [7:0] boost_target_out;
    logic boost_bypass_out, audio_cut_out, led_cut_out;
    int errors = 0, cmp_count = 0;
    logic [7:0] exp_t [4] = '{8'h62, 8'h41, 8'h00, 8'h50};
    // Short settle and step counts keep the run brief
    lapb_power_budget_mgr #(.SETTLE_CYCLES(8), .LED_STEP_CYCLES(4))
        u_lapb_power_budget_mgr (.sys_clk_in, .nrst_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .led_active_in, .thermal_near_in, .current_limit_in,
        .speaker_gain_field_in, .led_current_in, .classg_demand_in,
        .led_demand_in, .speaker_gain_out, .led_current_out,
        .boost_target_out, .boost_bypass_out, .audio_cut_out, .led_cut_out);
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string n, input logic [7:0] e,
        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // Inputs always change 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        tick(1);
        reg_wr_in = 1'b0;
        // Idle cycle so a following strobe never rises in the same step
        tick(1);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        tick(1);
        reg_rd_in = 1'b0;
        check("rdata", e, reg_rdata_out);
        tick(1);
    endtask : reg_read
    // Bounded wait on one of the two cut flags
    task automatic wait_cut(input bit led);
        for (int n = 0; (led ? led_cut_out : audio_cut_out) !== 1'b1; n++)
        begin
            if (n > 200) begin
                errors++;
                $display("Error wait for cut flag timed out");
                print_verdict();
            end
            tick(1);
        end
    endtask : wait_cut
    initial begin
        tick(4);
        nrst_in = 1'b1;
        reg_read(8'h0D, 8'h02);
        check("bypass", 8'h01, {7'h0, boost_bypass_out});
        reg_write(8'h0D, 8'hFF);
        reg_write(8'h0E, 8'h00);
        reg_read(8'h0D, 8'h1B);
        reg_read(8'h0E, 8'h00);
        $display("Test register done");
        led_active_in = 1'b1;
        for (int m = 0; m < 4; m++) begin
            reg_write(8'h0D, 8'(m));
            tick(2);
            check("target", exp_t[m], boost_target_out);
            check("bypass", {7'h0, m == 2}, {7'h0, boost_bypass_out});
        end
        reg_write(8'h0D, 8'h01);
        led_active_in = 1'b0;
        tick(2);
        check("target", 8'h00, boost_target_out);
        check("bypass", 8'h01, {7'h0, boost_bypass_out});
        $display("Test boost done");
        reg_write(8'h0D, 8'h00);
        led_active_in = 1'b1;
        current_limit_in = 1'b1;
        wait_cut(1'b0);
        check("gain", 8'h02, {5'h0, speaker_gain_out});
        wait_cut(1'b1);
        check("led", 8'h08, {4'h0, led_current_out});
        led_active_in = 1'b0;
        current_limit_in = 1'b0;
        tick(4);
        check("gain", 8'h03, {5'h0, speaker_gain_out});
        check("led", 8'h09, {4'h0, led_current_out});
        $display("Test auto cut done");
        reg_write(8'h0D, 8'h18);
        led_active_in = 1'b1;
        thermal_near_in = 1'b1;
        tick(30);
        check("gain", 8'h03, {5'h0, speaker_gain_out});
        check("led", 8'h09, {4'h0, led_current_out});
        check("cuts", 8'h00, {6'h0, audio_cut_out, led_cut_out});
        led_active_in = 1'b0;
        thermal_near_in = 1'b0;
        tick(2);
        $display("Test user policy done");
        // LED policy set: audio cut once, then LED current left alone
        reg_write(8'h0D, 8'h10);
        led_active_in = 1'b1;
        current_limit_in = 1'b1;
        wait_cut(1'b0);
        tick(30);
        check("gain", 8'h02, {5'h0, speaker_gain_out});
        check("led", 8'h09, {4'h0, led_current_out});
        check("cuts", 8'h02, {6'h0, audio_cut_out, led_cut_out});
        led_active_in = 1'b0;
        current_limit_in = 1'b0;
        tick(4);
        check("gain", 8'h03, {5'h0, speaker_gain_out});
        $display("Test led policy done");
        // Lowest audible gain is never cut, so overload goes to LED cut
        speaker_gain_field_in = 3'h1;
        reg_write(8'h0D, 8'h00);
        led_active_in = 1'b1;
        current_limit_in = 1'b1;
        wait_cut(1'b1);
        check("gain", 8'h01, {5'h0, speaker_gain_out});
        check("cuts", 8'h01, {6'h0, audio_cut_out, led_cut_out});
        check("led", 8'h08, {4'h0, led_current_out});
        led_active_in = 1'b0;
        current_limit_in = 1'b0;
        tick(4);
        speaker_gain_field_in = 3'h3;
        tick(2);
        $display("Test gain floor done");
        print_verdict();
    end
endmodule : tb_lapb_power_budget_mgr
